// *** design/spi_frame_pkg.sv ***
package spi_frame_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int BIT_RW = 15;
	localparam int BIT_SPACE = 14;
	localparam int ADDR_HI = 13;
	localparam int ADDR_LO = 9;
	localparam int BIT_PARITY = 8;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam logic [4:0] FRAME_CLKS = 5'h10;
	localparam logic [4:0] CNT_SAT = 5'h11;
	localparam logic [4:0] ADDR_DONE_CNT = 5'h06;
	localparam logic [4:0] LOWBYTE_CNT = 5'h07;
	localparam logic [2:0] PIN_IDLE = 3'h2;

	// ----------------------------------------
	// Summary source widths
	// ----------------------------------------
	localparam int WAKE_W = 6;
	localparam int CAN_W = 8;
	localparam int LIN_W = 4;
	localparam int IO_W = 5;
	localparam int PRE_W = 8;
	localparam int CORE_W = 3;
	localparam int AUX_W = 15;

	// ----------------------------------------
	// Communication error byte
	// ----------------------------------------
	localparam int ERR_W = 4;
	localparam int ERR_SECURE = 0;
	localparam int ERR_CLOCK = 1;
	localparam int ERR_INVALID = 2;
	localparam int ERR_PARITY = 3;
	localparam logic [3:0] ERR_READ_CLR = 4'hc;
	localparam logic [4:0] DIAG_ERR_ADDR = 5'h13;

	// ----------------------------------------
	// Fail-safe address classes, one bit per address
	// ----------------------------------------
	localparam logic [31:0] FS_USED_MASK = 32'h001efffe;
	localparam logic [31:0] FS_INIT_MASK = 32'h000e107a;
	localparam logic [31:0] FS_RO_MASK = 32'h0010e000;
	localparam logic [31:0] FS_SECURED_MASK = 32'h00000c00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int FS_GAP_NS = 3500;
	localparam int FS_GAP_CYC = (FS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = 4;
	localparam int CS_MIN_HIGH_CYC = 8;
	localparam int GAP_W = 8;
	localparam logic [7:0] FS_GAP_CNT = 8'(FS_GAP_CYC);
	localparam logic [7:0] CS_MIN_HIGH_CNT = 8'(CS_MIN_HIGH_CYC);
	localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
	localparam logic [7:0] GAP_SAT = 8'hff;

	// ----------------------------------------
	// Primary command port
	// ----------------------------------------
	localparam int HOST_ADDR_W = 4;
	localparam int HOST_DATA_W = 16;
	localparam logic [3:0] HOST_CMD_OFS = 4'h0;
	localparam logic [3:0] HOST_STAT_OFS = 4'h4;
	localparam logic [3:0] HOST_RESP_OFS = 4'h8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

endpackage

// *** design/spi_link_if.sv ***
`timescale 1ns/1ps
interface spi_link_if;
	// Link wires
	logic sclk;
	logic chip_select_n;
	logic mosi;
	logic miso;

	// Primary drives clock, select and command data
	modport primary (
		output sclk,
		output chip_select_n,
		output mosi,
		input miso
	);

	// Secondary answers on miso
	modport secondary (
		input sclk,
		input chip_select_n,
		input mosi,
		output miso
	);
endinterface

// *** design/spi_frame_device.sv ***
`timescale 1ns/1ps
// Behaviour
// - One 16-bit frame per chip select low
// - Top bit: zero read, one write
// - Bit 14 picks main or fail-safe space
// - Bits 13 to 9 are address, MSB first
// - Write parity makes total ones odd
// - Reads send zero parity and zero data
// - Upper byte summary; write lower byte extended
// - Read lower byte returns selected register
// - Fail-safe accesses need 3.5 us gap
// - Bit 15 ORs communication error flags
// - Bit 14 ORs wake-up source flags
// - Bit 13 ORs CAN diagnostic flags
// - Bit 12 ORs LIN error flags
// - Bit 11 ORs input change flags
// - Bit 10 ORs pre-regulator and battery events
// - Bit 9 ORs core supply events
// - Bit 8 ORs auxiliary supply events
// - Secure nibble mismatch sets sticky error
// - Clock count not 16 sets sticky error
// - Malformed or forbidden fail-safe access flagged
// - Secure nibble derived from upper data nibble
module spi_frame_device (
	// System
	input wire logic core_clk,
	input wire logic reset,
	// Link to the primary
	spi_link_if.secondary link,
	// Event sources for the summary byte, and the init phase for fail-safe writes
	input wire logic [spi_frame_pkg::WAKE_W-1:0] wake_flags,
	input wire logic [spi_frame_pkg::CAN_W-1:0] can_flags,
	input wire logic [spi_frame_pkg::LIN_W-1:0] lin_flags,
	input wire logic [spi_frame_pkg::IO_W-1:0] io_flags,
	input wire logic [spi_frame_pkg::PRE_W-1:0] pre_flags,
	input wire logic pre_state,
	input wire logic [spi_frame_pkg::CORE_W-1:0] core_flags,
	input wire logic core_state,
	input wire logic [spi_frame_pkg::AUX_W-1:0] aux_flags,
	input wire logic init_phase,
	// Register write side
	output logic wr_strobe,
	output logic wr_space,
	output logic [spi_frame_pkg::ADDR_W-1:0] wr_addr,
	output logic [spi_frame_pkg::DATA_W-1:0] wr_data,
	// Register read side
	output logic rd_space,
	output logic [spi_frame_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [spi_frame_pkg::DATA_W-1:0] rd_data,
	output logic rd_done,
	// Sticky communication errors
	output logic [spi_frame_pkg::ERR_W-1:0] err_flags
);
	import spi_frame_pkg::*;

	// Address class lookup, used for several classes
	function automatic logic addr_in(input logic [31:0] mask,
		input logic [ADDR_W-1:0] a);
		return mask[a];
	endfunction

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic [2:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
	wire logic [2:0] pin_raw, agree, pin_next;

	// Order: sclk, chip select, mosi
	assign pin_raw = {link.sclk, link.chip_select_n, link.mosi};
	// A change counts only once stages two and three agree
	assign agree = ~(sync2_reg ^ sync3_reg);
	assign pin_next = (agree & sync3_reg) | (~agree & pin_reg);

	// Three stages; stage one feeds only stage two
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1_reg <= PIN_IDLE;
			sync2_reg <= PIN_IDLE;
			sync3_reg <= PIN_IDLE;
			pin_reg <= PIN_IDLE;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg <= pin_next;
		end
	end

	wire logic in_frame, cs_fall, cs_rise, clk_rise, clk_fall, mosi_bit;

	// Clock edges seen only while selected
	assign in_frame = ~pin_reg[1];
	assign cs_fall = pin_reg[1] & ~pin_next[1];
	assign cs_rise = ~pin_reg[1] & pin_next[1];
	assign clk_rise = in_frame & ~pin_reg[2] & pin_next[2];
	assign clk_fall = in_frame & pin_reg[2] & ~pin_next[2];
	assign mosi_bit = pin_next[0];

	// ----------------------------------------
	// Summary byte
	// ----------------------------------------
	logic [ERR_W-1:0] err_reg;
	wire logic [7:0] summary;

	// Follows the sources, so a source cleared on read clears it
	assign summary = {
		|err_reg,
		|wake_flags,
		|can_flags,
		|lin_flags,
		|io_flags,
		(|pre_flags) | ~pre_state,
		(|core_flags) | ~core_state,
		|aux_flags
	};

	// ----------------------------------------
	// Shift path
	// ----------------------------------------
	logic [4:0] cnt_reg;
	logic [FRAME_BITS-1:0] rx_reg, out_reg;
	logic miso_reg, rd_space_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	wire logic [4:0] cnt_inc;
	wire logic [3:0] bit_sel;
	wire logic diag_sel;
	wire logic [7:0] err_byte, low_byte;

	// Saturate so an overlong frame stays wrong
	assign cnt_inc = (cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + 5'h01;
	// After n rises the next bit out is 15 - n
	assign bit_sel = ~cnt_reg[3:0];
	assign diag_sel = ~rd_space_reg & (rd_addr_reg == DIAG_ERR_ADDR);
	assign err_byte = {{(8 - ERR_W){1'b0}}, err_reg};
	// rx_reg[6] is the op bit once seven bits are in
	assign low_byte = (rx_reg[6] | diag_sel) ? err_byte
		: rd_data;

	// Capture on rise, MSB first
	always_ff @(posedge core_clk) begin
		if (reset || cs_fall) begin
			cnt_reg <= 5'h00;
			rx_reg <= '0;
		end else if (clk_rise) begin
			cnt_reg <= cnt_inc;
			rx_reg <= {rx_reg[14:0], mosi_bit};
		end
	end

	// Address known after the seventh rise
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_space_reg <= 1'b0;
			rd_addr_reg <= '0;
		end else if (clk_rise && cnt_reg == ADDR_DONE_CNT) begin
			rd_space_reg <= rx_reg[4];
			rd_addr_reg <= {rx_reg[3:0], mosi_bit};
		end
	end

	// Upper byte fixed at select, lower byte chosen mid-frame
	always_ff @(posedge core_clk) begin
		if (reset) begin
			out_reg <= '0;
		end else if (cs_fall) begin
			out_reg <= {summary, 8'h00};
		end else if (clk_rise && cnt_reg == LOWBYTE_CNT) begin
			out_reg[7:0] <= low_byte;
		end
	end

	// Output changes at select fall and on falling clock edges
	always_ff @(posedge core_clk) begin
		if (reset) begin
			miso_reg <= 1'b0;
		end else if (cs_fall) begin
			miso_reg <= summary[7];
		end else if (clk_fall) begin
			miso_reg <= out_reg[bit_sel];
		end
	end

	assign link.miso = miso_reg;

	// ----------------------------------------
	// Frame checks at deselect
	// ----------------------------------------
	wire logic f_write, f_fs, clk_bad, par_bad, malformed;
	wire logic fs_bad, sec_bad, good, do_write, do_read, diag_clear;
	wire logic [ADDR_W-1:0] f_addr;
	wire logic [DATA_W-1:0] f_data;
	wire logic [3:0] sec_expect;

	assign f_write = rx_reg[BIT_RW];
	assign f_fs = rx_reg[BIT_SPACE];
	assign f_addr = rx_reg[ADDR_HI:ADDR_LO];
	assign f_data = rx_reg[DATA_W-1:0];
	// Anything but sixteen clocks is rejected whole
	assign clk_bad = cnt_reg != FRAME_CLKS;
	// Total ones including parity must be odd
	assign par_bad = f_write & ~(^rx_reg);
	assign malformed = ~f_write & (rx_reg[8:0] != 9'h000);
	assign fs_bad = f_fs & (~addr_in(FS_USED_MASK, f_addr) | malformed
		| (f_write & (addr_in(FS_RO_MASK, f_addr)
		| (addr_in(FS_INIT_MASK, f_addr) & ~init_phase))));
	assign sec_expect = {~f_data[5], ~f_data[4], f_data[7], f_data[6]};
	assign sec_bad = f_fs & f_write & addr_in(FS_SECURED_MASK, f_addr)
		& (f_data[3:0] != sec_expect);
	assign good = cs_rise & ~clk_bad & ~par_bad & ~fs_bad & ~sec_bad;
	assign do_write = good & f_write;
	assign do_read = good & ~f_write;
	assign diag_clear = do_read & ~f_fs & (f_addr == DIAG_ERR_ADDR);

	wire logic [ERR_W-1:0] err_set, err_clr;

	// Checks rank: clock, then parity, then access, then secure
	assign err_set[ERR_CLOCK] = cs_rise & clk_bad;
	assign err_set[ERR_PARITY] = cs_rise & ~clk_bad & par_bad;
	assign err_set[ERR_INVALID] = cs_rise & ~clk_bad & ~par_bad
		& fs_bad;
	assign err_set[ERR_SECURE] = cs_rise & ~clk_bad & ~par_bad
		& ~fs_bad & sec_bad;
	// Secure and clock errors leave only with reset
	assign err_clr = diag_clear ? ERR_READ_CLR : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			err_reg <= '0;
		end else begin
			err_reg <= err_set | (err_reg & ~err_clr);
		end
	end

	logic wr_strobe_reg, wr_space_reg, rd_done_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic [DATA_W-1:0] wr_data_reg;

	// Pulses; the write fields hold until the next write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_strobe_reg <= 1'b0;
			rd_done_reg <= 1'b0;
		end else begin
			wr_strobe_reg <= do_write;
			rd_done_reg <= do_read;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_space_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
		end else if (do_write) begin
			wr_space_reg <= f_fs;
			wr_addr_reg <= f_addr;
			wr_data_reg <= f_data;
		end
	end

	assign wr_strobe = wr_strobe_reg;
	assign wr_space = wr_space_reg;
	assign wr_addr = wr_addr_reg;
	assign wr_data = wr_data_reg;
	assign rd_space = rd_space_reg;
	assign rd_addr = rd_addr_reg;
	assign rd_done = rd_done_reg;
	assign err_flags = err_reg;

endmodule

// *** design/spi_frame_primary.sv ***
`timescale 1ns/1ps
module spi_frame_primary (
	// System
	input wire logic core_clk,
	input wire logic reset,
	// Software register port
	input wire logic [spi_frame_pkg::HOST_ADDR_W-1:0] addr,
	input wire logic [spi_frame_pkg::HOST_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [spi_frame_pkg::HOST_DATA_W-1:0] rdata,
	// Link to the device
	spi_link_if.primary link
);
	import spi_frame_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_LEAD, ST_HIGH, ST_LOW, ST_TRAIL
	} host_state_t;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	host_state_t state_reg;
	host_state_t state_next;
	wire logic cmd_take;
	wire logic resp_read;
	wire logic parity;
	wire logic [FRAME_BITS-1:0] cmd_frame;

	// Commands while busy are dropped
	assign cmd_take = wr & (addr == HOST_CMD_OFS) & (state_reg == ST_IDLE);
	assign resp_read = rd & (addr == HOST_RESP_OFS);
	// Odd total of ones over the whole frame
	assign parity = ~(^{wdata[15:9], wdata[7:0]});
	assign cmd_frame = wdata[BIT_RW]
		? {wdata[15:9], parity, wdata[7:0]}
		: {wdata[15:9], 9'h000};

	// ----------------------------------------
	// Spacing counters
	// ----------------------------------------
	logic [GAP_W-1:0] cs_high_reg;
	logic [GAP_W-1:0] fs_gap_reg;
	logic frame_fs_reg;
	logic frame_end;
	wire logic gap_ok;

	// Fail-safe frames also wait out the long gap
	assign gap_ok = (cs_high_reg >= CS_MIN_HIGH_CNT)
		& (~frame_fs_reg | (fs_gap_reg >= FS_GAP_CNT));

	// Start saturated so the first frame goes at once
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cs_high_reg <= GAP_SAT;
			fs_gap_reg <= GAP_SAT;
		end else begin
			cs_high_reg <= frame_end ? '0
				: (cs_high_reg == GAP_SAT) ? cs_high_reg
				: cs_high_reg + 8'h01;
			fs_gap_reg <= (frame_end && frame_fs_reg) ? '0
				: (fs_gap_reg == GAP_SAT) ? fs_gap_reg
				: fs_gap_reg + 8'h01;
		end
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	logic [7:0] phase_reg;
	logic [7:0] phase_next;
	logic [4:0] bit_reg;
	logic [4:0] bit_next;
	logic [FRAME_BITS-1:0] tx_reg;
	logic [FRAME_BITS-1:0] tx_next;
	logic [FRAME_BITS-1:0] rx_reg;
	logic [FRAME_BITS-1:0] rx_next;
	logic sclk_reg;
	logic sclk_next;
	logic cs_n_reg;
	logic cs_n_next;
	logic mosi_reg;
	logic mosi_next;
	wire logic half_done;

	assign half_done = phase_reg == HALF_LAST;

	// Data moves on falling sclk, device samples on rising
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg + 8'h01;
		bit_next = bit_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		sclk_next = sclk_reg;
		cs_n_next = cs_n_reg;
		mosi_next = mosi_reg;
		frame_end = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_take) begin
					tx_next = cmd_frame;
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				phase_next = '0;
				bit_next = '0;
				if (gap_ok) begin
					cs_n_next = 1'b0;
					mosi_next = tx_reg[BIT_RW];
					state_next = ST_LEAD;
				end
			end
			ST_LEAD, ST_LOW: begin
				if (half_done) begin
					sclk_next = 1'b1;
					phase_next = '0;
					state_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (half_done) begin
					sclk_next = 1'b0;
					phase_next = '0;
					rx_next = {rx_reg[14:0], link.miso};
					tx_next = {tx_reg[14:0], 1'b0};
					mosi_next = tx_reg[14];
					bit_next = bit_reg + 5'h01;
					state_next = (bit_reg == 5'h0f) ? ST_TRAIL : ST_LOW;
				end
			end
			ST_TRAIL: begin
				if (half_done) begin
					cs_n_next = 1'b1;
					frame_end = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			phase_reg <= '0;
			bit_reg <= '0;
			tx_reg <= '0;
			rx_reg <= '0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			bit_reg <= bit_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
		end
	end

	// Pins idle with select high and clock low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end else begin
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			mosi_reg <= mosi_next;
		end
	end

	assign link.sclk = sclk_reg;
	assign link.chip_select_n = cs_n_reg;
	assign link.mosi = mosi_reg;

	// ----------------------------------------
	// Status and answer
	// ----------------------------------------
	logic [FRAME_BITS-1:0] resp_reg;
	logic done_reg;
	logic [HOST_DATA_W-1:0] rdata_reg;
	wire logic [HOST_DATA_W-1:0] stat_word;
	wire logic [HOST_DATA_W-1:0] rd_sel;

	assign stat_word = {14'h0000, done_reg, state_reg != ST_IDLE};
	assign rd_sel = (addr == HOST_STAT_OFS) ? stat_word
		: (addr == HOST_RESP_OFS) ? resp_reg
		: 16'h0000;

	// Done set wins over the clearing read
	always_ff @(posedge core_clk) begin
		if (reset) begin
			frame_fs_reg <= 1'b0;
			resp_reg <= '0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			if (cmd_take) begin
				frame_fs_reg <= wdata[BIT_SPACE];
			end
			if (frame_end) begin
				resp_reg <= rx_reg;
			end
			done_reg <= frame_end | (done_reg & ~resp_read);
			rdata_reg <= rd ? rd_sel : 16'h0000;
		end
	end

	assign rdata = rdata_reg;

endmodule

// *** verif/spi_link_assertions.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Frame tracking
// ----------------------------------------
module spi_link_assertions (
	// System
	input wire logic core_clk,
	input wire logic reset,
	// Link wires
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic mosi,
	input wire logic miso
);
	import spi_frame_pkg::*;
	logic sclk_d_reg;
	logic cs_d_reg;
	logic [4:0] rise_reg;
	logic [15:0] shift_reg;
	logic [7:0] gap_reg;
	logic [7:0] fall_gap_reg;
	wire sclk_rise = sclk & ~sclk_d_reg;
	wire cs_rise = chip_select_n & ~cs_d_reg;
	wire cs_fall = ~chip_select_n & cs_d_reg;

	// Rebuild each frame; gap runs from the last fail-safe frame end
	always_ff @(posedge core_clk) begin
		sclk_d_reg <= sclk;
		cs_d_reg <= chip_select_n;
		if (reset | chip_select_n) rise_reg <= 5'h0;
		else if (sclk_rise) rise_reg <= rise_reg + 5'h1;
		if (sclk_rise) shift_reg <= {shift_reg[14:0], mosi};
		if (reset) gap_reg <= GAP_SAT;
		else if (cs_rise & shift_reg[BIT_SPACE]) gap_reg <= 8'h1;
		else if (gap_reg != GAP_SAT) gap_reg <= gap_reg + 8'h1;
		if (cs_fall) fall_gap_reg <= gap_reg;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (reset);

	a_sclk_idle_low: assert property (
		chip_select_n |-> !sclk)
		else $error("link clock moved outside a frame");
	a_sclk_high_half: assert property (
		$rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high half not four cycles");
	a_sixteen_clocks: assert property (
		$rose(chip_select_n) |-> rise_reg == FRAME_CLKS)
		else $error("frame did not carry sixteen clocks");
	a_mosi_hold_high: assert property (
		sclk && $past(sclk) |-> $stable(mosi))
		else $error("command bit moved while clock high");
	a_write_odd_ones: assert property (
		$rose(chip_select_n) && shift_reg[BIT_RW] |-> ^shift_reg)
		else $error("write frame parity even");
	a_read_zero_tail: assert property (
		$rose(chip_select_n) && !shift_reg[BIT_RW]
		|-> shift_reg[8:0] == 9'h0)
		else $error("read frame tail not zero");
	a_select_min_high: assert property (
		$rose(chip_select_n) |-> chip_select_n[*8])
		else $error("select high time too short");
	a_fs_gap_kept: assert property (
		$rose(chip_select_n) && shift_reg[BIT_SPACE]
		|-> fall_gap_reg >= FS_GAP_CNT)
		else $error("fail-safe frames too close");

	// Main traffic kinds
	c_write_frame: cover property ($rose(chip_select_n) && shift_reg[15]);
	c_read_frame: cover property ($rose(chip_select_n) && !shift_reg[15]);
	c_fs_frame: cover property ($rose(chip_select_n) && shift_reg[14]);
endmodule

// *** verif/safety_pmic_spi_frame_bench.sv ***
`timescale 1ns/1ps
module safety_pmic_spi_frame_bench;
	import spi_frame_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [50:0] SRC_IDLE = 51'h880000000;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic init_phase = 1'b0;
	logic [50:0] src = SRC_IDLE;
	logic [15:0] rdata;
	logic wr_strobe, wr_space, rd_space, rd_done;
	logic [4:0] wr_addr, rd_addr;
	logic [7:0] wr_data;
	logic [3:0] err_flags, err2;
	logic [13:0] wr_last = 14'h0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	int cyc = 0;
	int error_cnt = 0;
	int total_checks = 0;
	int pos [9] = '{2, 9, 15, 20, 27, 31, 33, 35, 44};
	int sb [9] = '{14, 13, 12, 11, 10, 10, 9, 9, 8};
	// Command, answer, last write, errors, write count, init phase
	logic [63:0] tbl [12] = '{64'h8ca5_0000_06a5_0100,
		64'hc433_0000_2233_0200, 64'hc25a_0000_2233_4200,
		64'h2600_8004_2233_0200, 64'hc25a_0000_215a_0301,
		64'hda11_0000_215a_4300, 64'h2600_8004_215a_0300,
		64'h6000_00d0_215a_4300, 64'h2600_8004_215a_0300,
		64'hd4a6_0000_2aa6_0400, 64'hd4a5_0000_2aa6_1400,
		64'h2600_8001_2aa6_1400};
	// Register content is a pattern of its own space and address
	wire logic [7:0] rd_data = {rd_space, 2'h2, rd_addr};

	spi_link_if link ();
	spi_link_if link2 ();
	spi_frame_primary spi_frame_primary_inst (.core_clk(core_clk),
		.reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(link));
	spi_frame_device spi_frame_device_inst (.core_clk(core_clk),
		.reset(reset), .link(link), .wake_flags(src[5:0]),
		.can_flags(src[13:6]), .lin_flags(src[17:14]),
		.io_flags(src[22:18]), .pre_flags(src[30:23]),
		.pre_state(src[31]), .core_flags(src[34:32]),
		.core_state(src[35]), .aux_flags(src[50:36]),
		.init_phase(init_phase), .wr_strobe(wr_strobe),
		.wr_space(wr_space), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_space(rd_space), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_done(rd_done), .err_flags(err_flags));
	// Second device faces the bench's own faulty driver
	spi_frame_device spi_frame_device_inst_b (.core_clk(core_clk),
		.reset(reset), .link(link2), .wake_flags(src[5:0]),
		.can_flags(src[13:6]), .lin_flags(src[17:14]),
		.io_flags(src[22:18]), .pre_flags(src[30:23]),
		.pre_state(src[31]), .core_flags(src[34:32]),
		.core_state(src[35]), .aux_flags(src[50:36]),
		.init_phase(init_phase), .wr_strobe(), .wr_space(),
		.wr_addr(), .wr_data(), .rd_space(), .rd_addr(),
		.rd_data(8'h00), .rd_done(), .err_flags(err2));
	spi_link_assertions spi_link_assertions_inst (.core_clk(core_clk),
		.reset(reset), .sclk(link.sclk),
		.chip_select_n(link.chip_select_n), .mosi(link.mosi),
		.miso(link.miso));

	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;

	// Register-side counts and the hang limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (wr_strobe === 1'b1) wr_cnt <= wr_cnt + 1;
		if (wr_strobe === 1'b1) wr_last <= {wr_space, wr_addr, wr_data};
		if (rd_done === 1'b1) rd_cnt <= rd_cnt + 1;
		if (cyc == 40000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task host_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task host_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Poll is bounded; strobes land a few cycles after select rises
	task frame(input logic [15:0] cmd, output logic [15:0] resp);
		logic [15:0] st;
		int n;
		host_wr(HOST_CMD_OFS, cmd);
		st = 16'h0;
		for (n = 0; n < 600 && st[STAT_DONE] !== 1'b1; n++)
			host_rd(HOST_STAT_OFS, st);
		chk_flag({2'h0, st[1:0]}, 4'h2);
		host_rd(HOST_RESP_OFS, resp);
		repeat (8) @(posedge core_clk);
	endtask

	// Bit-banged frame with any clock count
	task raw_frame(input logic [15:0] bits, input int clks);
		int i;
		@(posedge core_clk);
		link2.chip_select_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < clks; i++) begin
			link2.mosi <= bits[15 - (i % 16)];
			repeat (4) @(posedge core_clk);
			link2.sclk <= 1'b1;
			repeat (4) @(posedge core_clk);
			link2.sclk <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		link2.chip_select_n <= 1'b1;
		link2.mosi <= ~bits[0];
		repeat (20) @(posedge core_clk);
	endtask

	task chk_resp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task chk_flag(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t flags %h expected %h", $time, got, exp);
		end
	endtask

	task conclude();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [15:0] r;
		logic [15:0] e;
		int k;
		link2.sclk <= 1'b0;
		link2.chip_select_n <= 1'b1;
		link2.mosi <= 1'b0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (6) @(posedge core_clk);
		// One event source at a time, read back through main space
		for (k = 0; k < 10; k++) begin
			src <= (k < 9) ? SRC_IDLE ^ (51'h1 << pos[k]) : SRC_IDLE;
			frame({2'h0, 5'(k + 1), 9'h0}, r);
			e = ((k < 9) ? 16'h1 << sb[k] : 16'h0) | {11'h2, 5'(k + 1)};
			chk_resp(r, e);
		end
		chk_flag(4'(rd_cnt), 4'ha);
		$display("summary test done");
		// Accepted accesses in both spaces, refused ones in the fail-safe space
		for (k = 0; k < 12; k++) begin
			init_phase <= tbl[k][0];
			frame(tbl[k][63:48], r);
			chk_resp(r, tbl[k][47:32]);
			chk_resp({2'h0, wr_last}, tbl[k][31:16]);
			chk_flag(err_flags, tbl[k][15:12]);
			chk_flag(4'(wr_cnt), tbl[k][11:8]);
		end
		$display("access test done");
		// Faults only a misbehaving primary can make
		raw_frame(16'h8da5, 16);
		chk_flag(err2, 4'h8);
		raw_frame(16'h2600, 16);
		chk_flag(err2, 4'h0);
		raw_frame(16'h2600, 15);
		chk_flag(err2, 4'h2);
		raw_frame(16'h2600, 17);
		raw_frame(16'h2600, 16);
		chk_flag(err2, 4'h2);
		raw_frame(16'h4201, 16);
		chk_flag(err2, 4'h6);
		$display("fault test done");
		// Reset clears every sticky error, the secure and clock ones included
		reset <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk_flag(err_flags, 4'h0);
		chk_flag(err2, 4'h0);
		$display("reset test done");
		conclude();
	end
endmodule
